//--- core/adc_dev_port.sv
// converter end of the serial port: framing, shifting, status and power pins
// assumes: serial clock comes from the host; config and result words only
// change between frames, so the link side reads them without a crossing
`timescale 1ns/1ps
`default_nettype none
module adc_dev_port (
  // core clock and reset
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  // serial link
  adc_link_if.device                             link,
  // converter core
  input  wire logic                              conv_done,
  input  wire logic [adc_port_pkg::DATA_W-1:0]   conv_result,
  output logic                                   conv_start,
  output logic                                   sampling,
  // control state
  output logic                                   power_down,
  output logic                                   sclk_conv_clk,
  output logic      [adc_port_pkg::CMD_W-1:0]    cmd_sel,
  output logic      [adc_port_pkg::DATA_W-1:0]   config_word
);
  logic                                frame_clr_n, dsp_r, spi_tgl_r, spi_en, armed_r;
  logic                                dsp_tgl_r, dsp_en, live, frame_done, is_select;
  logic                                one_shot, eoc_sel, cst_rise, status_r;
  logic [adc_port_pkg::CNT_W-1:0]      spi_cnt_r, spi_ocnt_r, dsp_cnt_r, dsp_ocnt_r, ocnt;
  logic [adc_port_pkg::FRAME_BITS-1:0] spi_sh_r, dsp_sh_r, tx_word, rx_word;
  logic [adc_port_pkg::CMD_W-1:0]      spi_cmd_r, dsp_cmd_r, out_cmd, rx_cmd;
  logic [adc_port_pkg::DATA_W-1:0]     cfg_r, result_r;
  logic [adc_port_pkg::DEV_SYNC_W-1:0] sy, prev_r, fell, flip;

  // link side: chip select high holds the frame counters cleared
  assign frame_clr_n = rst_n & ~link.cs_n;

  // framing chosen once per frame
  always_ff @(negedge link.cs_n or negedge rst_n) begin
    if (!rst_n) begin
      dsp_r <= 1'b0;
    end else begin
      dsp_r <= ~link.frame_sync;
    end
  end

  // microprocessor framing: capture on rising clock edges
  assign spi_en = ~link.cs_n & ~dsp_r & (spi_cnt_r != adc_port_pkg::CNT_FULL);

  always_ff @(posedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      spi_cnt_r <= adc_port_pkg::CNT_ZERO;
    end else if (spi_en) begin
      spi_cnt_r <= spi_cnt_r + adc_port_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      spi_sh_r  <= '0;
      spi_cmd_r <= adc_port_pkg::PAD4;
      spi_tgl_r <= 1'b0;
    end else if (spi_en) begin
      spi_sh_r <= {spi_sh_r[adc_port_pkg::FRAME_BITS-2:0], link.serial_in};
      if (spi_cnt_r == adc_port_pkg::CNT_CMD - adc_port_pkg::CNT_ONE) begin
        spi_cmd_r <= {spi_sh_r[2:0], link.serial_in};
      end
      if (spi_cnt_r == adc_port_pkg::CNT_FULL - adc_port_pkg::CNT_ONE) begin
        spi_tgl_r <= ~spi_tgl_r;
      end
    end
  end

  // output index moves on falling edges, valid at the next rising
  always_ff @(negedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      spi_ocnt_r <= adc_port_pkg::CNT_ZERO;
    end else begin
      spi_ocnt_r <= spi_cnt_r;
    end
  end

  // sync framing: a low sync at a falling edge starts a new frame
  assign dsp_en = armed_r & link.frame_sync & (dsp_cnt_r != adc_port_pkg::CNT_FULL);

  always_ff @(negedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      armed_r   <= 1'b0;
      dsp_cnt_r <= adc_port_pkg::CNT_ZERO;
    end else if (dsp_r && !link.frame_sync) begin
      armed_r   <= 1'b1;
      dsp_cnt_r <= adc_port_pkg::CNT_ZERO;
    end else if (dsp_en) begin
      dsp_cnt_r <= dsp_cnt_r + adc_port_pkg::CNT_ONE;
    end
  end

  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_sh_r  <= '0;
      dsp_cmd_r <= adc_port_pkg::PAD4;
      dsp_tgl_r <= 1'b0;
    end else if (dsp_en) begin
      dsp_sh_r <= {dsp_sh_r[adc_port_pkg::FRAME_BITS-2:0], link.serial_in};
      if (dsp_cnt_r == adc_port_pkg::CNT_CMD - adc_port_pkg::CNT_ONE) begin
        dsp_cmd_r <= {dsp_sh_r[2:0], link.serial_in};
      end
      if (dsp_cnt_r == adc_port_pkg::CNT_FULL - adc_port_pkg::CNT_ONE) begin
        dsp_tgl_r <= ~dsp_tgl_r;
      end
    end
  end

  // lags the capture count by one rising edge, so the msb holds a full bit
  always_ff @(posedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      dsp_ocnt_r <= adc_port_pkg::CNT_ZERO;
    end else begin
      dsp_ocnt_r <= dsp_cnt_r;
    end
  end

  // output word and its enable
  assign ocnt    = dsp_r ? dsp_ocnt_r : spi_ocnt_r;
  assign out_cmd = dsp_r ? dsp_cmd_r : spi_cmd_r;
  assign live    = dsp_r ? armed_r : 1'b1;

  // command is known after four bits, exactly where the pad bits end
  always_comb begin
    if (out_cmd == adc_port_pkg::CMD_READ_CFG && ocnt >= adc_port_pkg::CNT_CMD) begin
      tx_word = {adc_port_pkg::PAD4, cfg_r};
    end else begin
      tx_word = {result_r, adc_port_pkg::PAD4};
    end
  end

  assign link.serial_out      = tx_word[adc_port_pkg::BIT_MSB - ocnt[3:0]];
  assign link.serial_out_oe_n = link.cs_n | ~live
                              | (ocnt == adc_port_pkg::CNT_FULL);

  // core side: pins and frame toggles cross here
  sync2 #(
    .W    (adc_port_pkg::DEV_SYNC_W),
    .INIT (adc_port_pkg::DEV_SYNC_INIT)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({link.hard_power_down_n, link.conversion_start_n, link.frame_sync,
             link.cs_n, dsp_tgl_r, spi_tgl_r}),
    .q     (sy)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= adc_port_pkg::DEV_SYNC_INIT;
    end else begin
      prev_r <= sy;
    end
  end

  assign fell       = prev_r & ~sy;
  assign flip       = prev_r ^ sy;
  assign frame_done = flip[adc_port_pkg::SY_SPI] | flip[adc_port_pkg::SY_DSP];
  // shift registers stand still until the next frame, well after this read
  assign rx_word    = flip[adc_port_pkg::SY_DSP] ? dsp_sh_r : spi_sh_r;
  assign rx_cmd     = rx_word[adc_port_pkg::FRAME_BITS-1 -: adc_port_pkg::CMD_W];
  assign is_select  = (rx_cmd <= adc_port_pkg::CMD_CH_LAST)
                    | ((rx_cmd >= adc_port_pkg::CMD_TEST_FIRST)
                      & (rx_cmd <= adc_port_pkg::CMD_TEST_LAST));
  assign one_shot   = cfg_r[adc_port_pkg::CFG_MODE_HI:adc_port_pkg::CFG_MODE_LO]
                      == adc_port_pkg::MODE_ONE_SHOT;
  assign eoc_sel    = cfg_r[adc_port_pkg::CFG_EOC_BIT];
  assign cst_rise   = ~prev_r[adc_port_pkg::SY_CST] & sy[adc_port_pkg::SY_CST];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r   <= adc_port_pkg::CFG_RST;
      cmd_sel <= adc_port_pkg::PAD4;
    end else if (frame_done) begin
      if (rx_cmd == adc_port_pkg::CMD_WRITE_CFG) begin
        cfg_r <= rx_word[adc_port_pkg::DATA_W-1:0];
      end
      if (is_select) begin
        cmd_sel <= rx_cmd;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= adc_port_pkg::RESULT_RST;
    end else if (conv_done) begin
      result_r <= conv_result;
    end
  end

  // sampling window only counts while chip select is high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sampling   <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      sampling   <= sy[adc_port_pkg::SY_CS] & ~sy[adc_port_pkg::SY_CST];
      conv_start <= (cst_rise & sy[adc_port_pkg::SY_CS]) | (frame_done & is_select);
    end
  end

  // status pin, active low; with eoc_sel low the assertion is placed last so it beats a clear, with eoc_sel high the clear wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 1'b1;
    end else if (eoc_sel) begin
      if (conv_done || !one_shot) begin
        status_r <= 1'b1;
      end else if (conv_start) begin
        status_r <= 1'b0;
      end
    end else begin
      if (fell[adc_port_pkg::SY_CS] || fell[adc_port_pkg::SY_FRM]) begin
        status_r <= 1'b1;
      end
      if (conv_done) begin
        status_r <= 1'b0;
      end
    end
  end

  assign link.status_n = status_r;

  // power down: pin wins; after it rises, any frame or start activity wakes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_down <= 1'b0;
    end else if (!sy[adc_port_pkg::SY_PWD]) begin
      power_down <= 1'b1;
    end else begin
      if (fell[adc_port_pkg::SY_CS] || fell[adc_port_pkg::SY_FRM]
          || fell[adc_port_pkg::SY_CST]) begin
        power_down <= 1'b0;
      end
      if (frame_done && rx_cmd == adc_port_pkg::CMD_SW_HARD_POWER_DOWN_N) begin
        power_down <= 1'b1;
      end
    end
  end

  assign sclk_conv_clk = cfg_r[adc_port_pkg::CFG_CLK_BIT];
  assign config_word   = cfg_r;
endmodule : adc_dev_port
`default_nettype wire

//--- core/adc_port_pkg.sv
// constants and types shared by both ends of the converter serial port
// assumes: compiled before the interface and the modules that name it
package adc_port_pkg;

  // frame shape
  localparam int                FRAME_BITS = 16;
  localparam int                CNT_W      = 5;
  localparam int                CMD_W      = 4;
  localparam int                DATA_W     = 12;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 5'h01;
  localparam logic [CNT_W-1:0]  CNT_CMD    = 5'h04;
  localparam logic [CNT_W-1:0]  CNT_FULL   = 5'h10;
  localparam logic [3:0]        BIT_MSB    = 4'hf;
  localparam logic [CMD_W-1:0]  PAD4       = 4'h0;

  // command codes in the top four bits
  localparam logic [CMD_W-1:0]  CMD_CH_LAST    = 4'h7;
  localparam logic [CMD_W-1:0]  CMD_SW_HARD_POWER_DOWN_N    = 4'h8;
  localparam logic [CMD_W-1:0]  CMD_READ_CFG   = 4'h9;
  localparam logic [CMD_W-1:0]  CMD_WRITE_CFG  = 4'ha;
  localparam logic [CMD_W-1:0]  CMD_TEST_FIRST = 4'hb;
  localparam logic [CMD_W-1:0]  CMD_TEST_LAST  = 4'hd;

  // configuration word fields
  localparam int                CFG_MODE_HI   = 6;
  localparam int                CFG_MODE_LO   = 5;
  localparam logic [1:0]        MODE_ONE_SHOT = 2'h0;
  localparam int                CFG_EOC_BIT   = 2;
  localparam int                CFG_CLK_BIT   = 4;
  localparam logic [DATA_W-1:0] CFG_RST       = 12'h000;
  localparam logic [DATA_W-1:0] RESULT_RST    = 12'h000;

  // synchroniser lanes, device core side
  localparam int                DEV_SYNC_W    = 6;
  localparam int                SY_SPI        = 0;
  localparam int                SY_DSP        = 1;
  localparam int                SY_CS         = 2;
  localparam int                SY_FRM        = 3;
  localparam int                SY_CST        = 4;
  localparam int                SY_PWD        = 5;
  localparam logic [5:0]        DEV_SYNC_INIT = 6'h3c;

  // synchroniser lanes, host side
  localparam int                HOST_SYNC_W    = 2;
  localparam int                HS_OUT         = 0;
  localparam int                HS_STAT        = 1;
  localparam logic [1:0]        HOST_SYNC_INIT = 2'h2;

  // host serial clock divider: half period is a least time
  localparam int                CLK_PERIOD_NS = 25;
  localparam int                SCLK_HALF_NS  = 100;
  localparam int                SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int                DIV_W         = 3;
  localparam logic [DIV_W-1:0]  DIV_ZERO      = 3'h0;
  localparam logic [DIV_W-1:0]  DIV_ONE       = 3'h1;
  localparam logic [DIV_W-1:0]  DIV_LAST      = DIV_W'(SCLK_HALF_CYC - 1);

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_LEAD  = 5'b00010,
    H_SHIFT = 5'b00100,
    H_TAIL  = 5'b01000,
    H_GAP   = 5'b10000
  } host_state_t;

endpackage : adc_port_pkg

//--- core/adc_link_if.sv
// pins between the host serial port and the converter serial port
// assumes: host drives the serial clock; device releases serial_out by its enable
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic frame_sync;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  logic conversion_start_n;
  logic status_n;
  logic hard_power_down_n;
  wire  serial_out_line;

  // released line shows the inverse, so a sample taken while released is caught
  assign serial_out_line = serial_out_oe_n ? ~serial_out : serial_out;

  modport device (
    input  cs_n, sclk, frame_sync, serial_in, conversion_start_n, hard_power_down_n,
    output serial_out, serial_out_oe_n, status_n
  );
  modport host (
    output cs_n, sclk, frame_sync, serial_in, conversion_start_n, hard_power_down_n,
    input  serial_out_line, status_n
  );
endinterface : adc_link_if
`default_nettype wire

//--- core/sync2.sv
// two-flop level synchroniser for a small vector
// assumes: each lane is a level or a toggle, never a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // lanes
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync2
`default_nettype wire

//--- core/adc_host_port.sv
// host end: makes the serial clock, frames one 16-bit word per request
// assumes: the converter end sits on the other side of adc_link_if
`timescale 1ns/1ps
`default_nettype none
module adc_host_port (
  // clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  rst_n,
  // serial link
  adc_link_if.host                                   link,
  // user requests
  input  wire logic                                  start,
  input  wire logic                                  dsp_mode,
  input  wire logic [adc_port_pkg::FRAME_BITS-1:0]   tx_word,
  input  wire logic                                  conv_start_req,
  input  wire logic                                  power_down_req,
  // user answers
  output logic                                       busy,
  output logic                                       rx_valid,
  output logic      [adc_port_pkg::FRAME_BITS-1:0]   rx_word,
  output logic                                       status_low
);
  adc_port_pkg::host_state_t           state_r;
  logic [adc_port_pkg::DIV_W-1:0]      div_r;
  logic                                tick;
  logic                                dsp_r;
  logic                                cs_n_r;
  logic                                sclk_r;
  logic                                frame_sync_r;
  logic [adc_port_pkg::FRAME_BITS-1:0] tx_sh_r;
  logic [adc_port_pkg::FRAME_BITS-1:0] rx_sh_r;
  logic [adc_port_pkg::CNT_W-1:0]      cnt_r;
  logic                                cap_edge;
  logic [adc_port_pkg::HOST_SYNC_W-1:0] sy;

  sync2 #(
    .W    (adc_port_pkg::HOST_SYNC_W),
    .INIT (adc_port_pkg::HOST_SYNC_INIT)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({link.status_n, link.serial_out_line}),
    .q     (sy)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= adc_port_pkg::DIV_ZERO;
    end else if (state_r == adc_port_pkg::H_IDLE || tick) begin
      div_r <= adc_port_pkg::DIV_ZERO;
    end else begin
      div_r <= div_r + adc_port_pkg::DIV_ONE;
    end
  end

  assign tick     = div_r == adc_port_pkg::DIV_LAST;
  // capture where the converter captures: rising without sync, falling with
  assign cap_edge = dsp_r ? sclk_r : ~sclk_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= adc_port_pkg::H_IDLE;
      dsp_r        <= 1'b0;
      cs_n_r       <= 1'b1;
      sclk_r       <= 1'b0;
      frame_sync_r <= 1'b1;
      tx_sh_r      <= '0;
      rx_sh_r      <= '0;
      cnt_r        <= adc_port_pkg::CNT_ZERO;
    end else begin
      case (state_r)
        adc_port_pkg::H_IDLE: begin
          if (start) begin
            // select falls a clock later: the converter latches a settled sync level
            dsp_r        <= dsp_mode;
            frame_sync_r <= ~dsp_mode;
            tx_sh_r      <= tx_word;
            cnt_r        <= adc_port_pkg::CNT_ZERO;
            state_r      <= adc_port_pkg::H_LEAD;
          end
        end
        adc_port_pkg::H_LEAD: begin
          cs_n_r <= 1'b0;
          if (tick) begin
            if (!dsp_r || sclk_r) begin
              sclk_r  <= 1'b0;
              state_r <= adc_port_pkg::H_SHIFT;
            end else begin
              sclk_r <= 1'b1;
            end
          end
        end
        adc_port_pkg::H_SHIFT: begin
          if (tick) begin
            sclk_r <= ~sclk_r;
            if (cap_edge) begin
              rx_sh_r <= {rx_sh_r[adc_port_pkg::FRAME_BITS-2:0], sy[adc_port_pkg::HS_OUT]};
              cnt_r   <= cnt_r + adc_port_pkg::CNT_ONE;
              if (dsp_r && cnt_r == adc_port_pkg::CNT_FULL - adc_port_pkg::CNT_ONE) begin
                state_r <= adc_port_pkg::H_TAIL;
              end
            end else begin
              frame_sync_r <= 1'b1;
              if (cnt_r != adc_port_pkg::CNT_ZERO) begin
                tx_sh_r <= {tx_sh_r[adc_port_pkg::FRAME_BITS-2:0], 1'b0};
              end
              if (!dsp_r && cnt_r == adc_port_pkg::CNT_FULL) begin
                state_r <= adc_port_pkg::H_TAIL;
              end
            end
          end
        end
        adc_port_pkg::H_TAIL: begin
          if (tick) begin
            cs_n_r       <= 1'b1;
            frame_sync_r <= 1'b1;
            state_r      <= adc_port_pkg::H_GAP;
          end
        end
        adc_port_pkg::H_GAP: begin
          if (tick) begin
            state_r <= adc_port_pkg::H_IDLE;
          end
        end
        default: begin
          state_r <= adc_port_pkg::H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_word  <= '0;
    end else begin
      rx_valid <= (state_r == adc_port_pkg::H_TAIL) & tick;
      if (state_r == adc_port_pkg::H_TAIL && tick) begin
        rx_word <= rx_sh_r;
      end
    end
  end

  // unused start request leaves the pin high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.conversion_start_n <= 1'b1;
      link.hard_power_down_n  <= 1'b1;
      status_low              <= 1'b0;
    end else begin
      link.conversion_start_n <= ~conv_start_req;
      link.hard_power_down_n  <= ~power_down_req;
      status_low              <= ~sy[adc_port_pkg::HS_STAT];
    end
  end

  assign busy            = state_r != adc_port_pkg::H_IDLE;
  assign link.cs_n       = cs_n_r;
  assign link.sclk       = sclk_r;
  assign link.frame_sync = frame_sync_r;
  assign link.serial_in  = tx_sh_r[adc_port_pkg::FRAME_BITS-1];

endmodule : adc_host_port
`default_nettype wire

//--- test/adc_link_asserts.sv
// checker on the link pins between the host end and the converter end
// assumes: instantiated beside the interface; pins follow the host clock
`timescale 1ns/1ps
`default_nettype none
module adc_link_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic frame_sync,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic status_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic spi_r;
  // framing kind latched from the sync level at select fall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) spi_r <= 1'b1;
    else if ($fell(cs_n)) spi_r <= frame_sync;
  end
  property p_cs_sclk; $changed(cs_n) |-> !sclk; endproperty
  a_cs_sclk: assert property (p_cs_sclk) else $error("select moved, clock high");
  property p_idle; cs_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock high while idle");
  property p_off; cs_n |-> serial_out_oe_n; endproperty
  a_off: assert property (p_off) else $error("output driven, select high");
  property p_open; $fell(cs_n) && frame_sync |=> !serial_out_oe_n; endproperty
  a_open: assert property (p_open) else $error("output not opened");
  property p_wait; $fell(cs_n) && !frame_sync |=> serial_out_oe_n; endproperty
  a_wait: assert property (p_wait) else $error("output opened early");
  property p_spi; $rose(sclk) && spi_r && !serial_out_oe_n |-> $stable(serial_out); endproperty
  a_spi: assert property (p_spi) else $error("bit moved on rise");
  property p_dsp;
    $fell(sclk) && !spi_r && !cs_n && !$past(serial_out_oe_n) |-> $stable(serial_out);
  endproperty
  a_dsp: assert property (p_dsp) else $error("bit moved on fall");
  property p_clr; $fell(cs_n) && !status_n |-> ##[1:8] status_n; endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
endmodule : adc_link_asserts
`default_nettype wire

//--- test/test_adc_serial_host_port.sv
// bench: host end and converter end joined by the link
// assumes: core files compiled first; converter core modelled here
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_host_port;
  logic        clock, rst_n, conv_done, start, dsp_mode, conv_start_req, power_down_req;
  logic        conv_start, sampling, power_down, sclk_conv_clk, busy, rx_valid, status_low;
  logic [3:0]  cmd_sel;
  logic [11:0] conv_result, config_word;
  logic [15:0] tx_word, rx_word;
  int          bad_count = 0, n_tests = 0, cycles = 0, n_starts = 0;
  adc_link_if i_adc_link_if ();
  adc_dev_port i_adc_dev_port (.clock(clock), .rst_n(rst_n), .link(i_adc_link_if.device),
    .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
    .sampling(sampling), .power_down(power_down), .sclk_conv_clk(sclk_conv_clk),
    .cmd_sel(cmd_sel), .config_word(config_word));
  adc_host_port i_adc_host_port (.clock(clock), .rst_n(rst_n), .link(i_adc_link_if.host),
    .start(start), .dsp_mode(dsp_mode), .tx_word(tx_word), .conv_start_req(conv_start_req),
    .power_down_req(power_down_req), .busy(busy), .rx_valid(rx_valid), .rx_word(rx_word),
    .status_low(status_low));
  // one-cycle start pulses, counted on the edge after they are launched
  always @(posedge clock) if (conv_start === 1'b1) n_starts++;
  adc_link_asserts i_adc_link_asserts (.clock(clock), .rst_n(rst_n),
    .cs_n(i_adc_link_if.cs_n), .sclk(i_adc_link_if.sclk),
    .frame_sync(i_adc_link_if.frame_sync), .serial_out(i_adc_link_if.serial_out),
    .serial_out_oe_n(i_adc_link_if.serial_out_oe_n), .status_n(i_adc_link_if.status_n));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // a run needs about 800 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic frame(input logic [15:0] w, input logic d);
    tx_word = w;
    dsp_mode = d;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (int k = 0; k < 300 && rx_valid !== 1'b1; k++) tick(1);
    chk(16'(rx_valid), 16'h0001);
    tick(6);
    chk(16'(busy), 16'h0000);
  endtask : frame
  task automatic pulse_done(input logic [11:0] r);
    conv_result = r;
    conv_done = 1'b1;
    tick(1);
    conv_done = 1'b0;
    tick(8);
  endtask : pulse_done
  task automatic t_int();
    frame(16'h1000, 1'b0);
    chk(16'(cmd_sel), 16'h0001);
    chk(16'(n_starts), 16'h0001);
    pulse_done(12'h5a3);
    chk(16'(status_low), 16'h0001);
    frame(16'h0000, 1'b1);
    chk(rx_word, 16'h5a30);
    chk(16'(status_low), 16'h0000);
    $display("t_int done");
  endtask : t_int
  task automatic t_cfg();
    frame(16'ha014, 1'b0);
    chk(16'(config_word), 16'h0014);
    chk(16'(sclk_conv_clk), 16'h0001);
    frame(16'h9000, 1'b1);
    chk(16'(rx_word[11:0]), 16'h0014);
    $display("t_cfg done");
  endtask : t_cfg
  task automatic t_eoc();
    conv_start_req = 1'b1;
    tick(8);
    chk(16'(sampling), 16'h0001);
    conv_start_req = 1'b0;
    tick(8);
    chk(16'(status_low), 16'h0001);
    chk(16'(n_starts), 16'h0003);
    pulse_done(12'h0c1);
    chk(16'(status_low), 16'h0000);
    $display("t_eoc done");
  endtask : t_eoc
  task automatic t_hard_power_down_n();
    power_down_req = 1'b1;
    tick(8);
    chk(16'(power_down), 16'h0001);
    power_down_req = 1'b0;
    tick(8);
    chk(16'(power_down), 16'h0001);
    frame(16'h9000, 1'b0);
    chk(16'(power_down), 16'h0000);
    chk(16'(rx_word[11:0]), 16'h0014);
    $display("t_hard_power_down_n done");
  endtask : t_hard_power_down_n
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    {rst_n, conv_done, start, dsp_mode, conv_start_req, power_down_req} = 6'h00;
    {conv_result, tx_word} = 28'h0;
    tick(3);
    rst_n = 1'b1;
    t_int();
    t_cfg();
    t_eoc();
    t_hard_power_down_n();
    give_verdict();
  end
endmodule : test_adc_serial_host_port
`default_nettype wire
